//--- aodb_conv_model.sv
// Converter and memory timing model: sample requests and late fills
`timescale 1ns/10ps
`default_nettype none
module aodb_conv_model
(
  // Clock, reset and bench commands
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fire,
  input wire logic late_on,
  // Toward the controller
  output logic sample_due,
  output logic fetch_late
);
  // One request pulse per command, lateness beside it
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      sample_due <= 1'b0;
      fetch_late <= 1'b0;
    end
    else
    begin
      sample_due <= fire && !sample_due;
      fetch_late <= late_on;
    end
endmodule
`default_nettype wire

//--- aodb_ctrl.sv
// Buffer handshake, status flags and interrupt line of the audio output DMA unit
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "aodb_defs.svh"
module aodb_ctrl
  import aodb_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sample path events
  input wire logic sample_due,
  input wire logic fetch_late,
  input wire logic global_powerdown,
  // Memory side
  output logic fetch_req,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic repeat_sample,
  output logic unit_asleep,
  output logic out_polarity,
  // Interrupt source twelve
  output logic irq
);
  initial
  begin
    if (ADDR_W < 8 || ADDR_W > 32)
      $error("ADDR_W out of range");
  end

  logic [ADDR_W-1:0] first_buffer_pointer;
  logic [ADDR_W-1:0] second_buffer_pointer;
  logic [31:0] buf_size;
  logic [31:0] sample_cnt;
  logic transmit_on;
  logic stay_awake;
  logic [3:0] irq_en;
  logic first_buffer_current;
  logic fill1;
  logic fill2;
  aodb_flags_t flags;
  aodb_state_t state;
  logic wr;
  logic soft_rst;
  logic active;
  logic cur_filled;
  logic step;
  logic last;
  logic rel1;
  logic rel2;
  logic clr_bwe;
  logic clr_udr;
  logic [31:0] rd_word;

  // Byte-lane aware write strobe helpers
  function automatic logic wbit(input logic [3:0] sel, input logic [31:0] d, input int unsigned pos);
    wbit = sel[pos/8] & d[pos];
  endfunction

  // Bus decode
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign soft_rst = wr && wb_adr_i == `AODB_CTL_OFS && wbit(wb_sel_i, wb_dat_i, `AODB_CTL_RESET); // [RULE15]
  assign rel1 = wr && wb_adr_i == `AODB_STAT_OFS && wbit(wb_sel_i, wb_dat_i, `AODB_CTL_REL1); // [RULE25]
  assign rel2 = wr && wb_adr_i == `AODB_STAT_OFS && wbit(wb_sel_i, wb_dat_i, `AODB_CTL_REL2);
  assign clr_bwe = wr && wb_adr_i == `AODB_STAT_OFS && wbit(wb_sel_i, wb_dat_i, `AODB_CTL_BWE_CLR);
  assign clr_udr = wr && wb_adr_i == `AODB_STAT_OFS && wbit(wb_sel_i, wb_dat_i, `AODB_CTL_UDR_CLR);
  // Unit runs only when enabled and not sleeping
  assign active = transmit_on && !(global_powerdown && !stay_awake); // [RULE16] [RULE18]
  assign cur_filled = first_buffer_current ? fill1 : fill2;
  assign step = active && sample_due && state == AODB_PLAY && !fetch_late;
  assign last = sample_cnt + 32'h1 >= buf_size;

  // Control register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      transmit_on <= 1'b0;
      stay_awake <= 1'b0;
      irq_en <= 4'h0;
      out_polarity <= 1'b0;
    end
    else if (soft_rst)
    begin
      transmit_on <= 1'b0;
      stay_awake <= 1'b0;
      irq_en <= 4'h0; // [RULE19]
      out_polarity <= 1'b0;
    end
    else if (wr && wb_adr_i == `AODB_CTL_OFS)
    begin
      if (wb_sel_i[1])
      begin
        transmit_on <= wb_dat_i[`AODB_CTL_TX_ON];
        stay_awake <= wb_dat_i[`AODB_CTL_STAY_AWAKE];
      end
      if (wb_sel_i[0])
      begin
        irq_en <= wb_dat_i[`AODB_CTL_UDR_EN:`AODB_CTL_BUF1_EN]; // [RULE19]
        out_polarity <= wb_dat_i[`AODB_CTL_POLARITY];
      end
    end
  end

  // Buffer pointers and size
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      first_buffer_pointer <= '0;
      second_buffer_pointer <= '0;
      buf_size <= 32'h0;
    end
    else if (soft_rst)
    begin
      first_buffer_pointer <= '0;
      second_buffer_pointer <= '0;
      buf_size <= 32'h0;
    end
    else if (wr && wb_sel_i == 4'hf)
    begin
      if (wb_adr_i == `AODB_FIRST_BUFFER_POINTER_OFS)
        first_buffer_pointer <= wb_dat_i[ADDR_W-1:0];
      if (wb_adr_i == `AODB_SECOND_BUFFER_POINTER_OFS)
        second_buffer_pointer <= wb_dat_i[ADDR_W-1:0];
      if (wb_adr_i == `AODB_SIZE_OFS)
        buf_size <= wb_dat_i;
    end
  end

  // Playback sequencer, buffer switching and fill state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= AODB_IDLE;
      first_buffer_current <= 1'b1;
      fill1 <= 1'b1;
      fill2 <= 1'b1;
      sample_cnt <= 32'h0;
    end
    else if (soft_rst)
    begin
      state <= AODB_IDLE;
      first_buffer_current <= 1'b1; // [RULE6]
      fill1 <= 1'b1;
      fill2 <= 1'b1;
      sample_cnt <= 32'h0;
    end
    else
    begin
      if (rel1)
        fill1 <= 1'b1; // [RULE3]
      if (rel2)
        fill2 <= 1'b1;
      case (state)
        AODB_IDLE:
        begin
          if (transmit_on)
            state <= cur_filled ? AODB_PLAY : AODB_STARVE;
        end
        AODB_PLAY:
        begin
          if (!transmit_on)
            state <= AODB_IDLE;
          else if (step)
          begin
            if (last)
            begin
              sample_cnt <= 32'h0;
              first_buffer_current <= !first_buffer_current; // [RULE2] [RULE22]
              if (first_buffer_current)
                fill1 <= rel1;
              else
                fill2 <= rel2;
              // Next buffer not yet released by software
              if (first_buffer_current ? !(fill2 || rel2) : !(fill1 || rel1))
                state <= AODB_STARVE;
            end
            else
              sample_cnt <= sample_cnt + 32'h1;
          end
        end
        AODB_STARVE:
        begin
          if (!transmit_on)
            state <= AODB_IDLE;
          else if (cur_filled) // [RULE23]
            state <= AODB_PLAY;
        end
        default:
          state <= AODB_IDLE;
      endcase
    end
  end

  // Sticky flags; a set beats a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      flags <= '0;
    else if (soft_rst)
      flags <= '0;
    else
    begin
      flags.drain1 <= (step && last && first_buffer_current) || (flags.drain1 && !rel1); // [RULE7] [RULE14]
      flags.drain2 <= (step && last && !first_buffer_current) || (flags.drain2 && !rel2); // [RULE8]
      flags.bwe <= (active && sample_due && state == AODB_PLAY && fetch_late) || (flags.bwe && !clr_bwe); // [RULE9] [RULE20]
      flags.udr <= (active && sample_due && state == AODB_STARVE) || (flags.udr && !clr_udr); // [RULE10] [RULE11]
    end
  end

  // Interrupt line, registered from the flags, dropped the second edge after a clear write
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |({flags.udr, flags.bwe, flags.drain2, flags.drain1} & irq_en); // [RULE12] [RULE13] [RULE4]
  end

  // Memory fetch address and sample-path outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fetch_req <= 1'b0;
      fetch_addr <= '0;
      repeat_sample <= 1'b0;
      unit_asleep <= 1'b0;
    end
    else
    begin
      fetch_req <= step;
      fetch_addr <= (first_buffer_current ? first_buffer_pointer : second_buffer_pointer) + sample_cnt[ADDR_W-1:0];
      repeat_sample <= active && sample_due && (state == AODB_STARVE || fetch_late); // [RULE23] [RULE24]
      unit_asleep <= global_powerdown && !stay_awake; // [RULE18]
    end
  end

  // Read data mux; reset bit reads zero, release and clear bit positions read back status bits
  always_comb
  begin
    rd_word = 32'h0;
    case (wb_adr_i)
      `AODB_CTL_OFS:
      begin
        rd_word[`AODB_CTL_TX_ON] = transmit_on;
        rd_word[`AODB_CTL_STAY_AWAKE] = stay_awake;
        rd_word[`AODB_CTL_POLARITY] = out_polarity;
        rd_word[`AODB_CTL_UDR_EN:`AODB_CTL_BUF1_EN] = irq_en;
      end
      `AODB_STAT_OFS:
      begin
        rd_word[`AODB_ST_CUR1] = first_buffer_current; // [RULE6]
        rd_word[`AODB_ST_DRAIN1] = flags.drain1;
        rd_word[`AODB_ST_DRAIN2] = flags.drain2;
        rd_word[`AODB_ST_BWE] = flags.bwe;
        rd_word[`AODB_ST_UDR] = flags.udr;
        rd_word[`AODB_ST_FILL1] = fill1;
        rd_word[`AODB_ST_FILL2] = fill2;
        rd_word[`AODB_ST_STATE+2:`AODB_ST_STATE] = state; // [RULE21]
      end
      `AODB_FIRST_BUFFER_POINTER_OFS: rd_word[ADDR_W-1:0] = first_buffer_pointer;
      `AODB_SECOND_BUFFER_POINTER_OFS: rd_word[ADDR_W-1:0] = second_buffer_pointer;
      `AODB_SIZE_OFS: rd_word = buf_size;
      default: rd_word = 32'h0;
    endcase
  end

  // Wishbone answer, one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_word;
    end
  end
endmodule
`default_nettype wire

//--- aodb_defs.svh
// Register offsets and field positions of the audio output buffer controller
// Overview of operation
// RULE1 - Software refills buffer one before buffer two drains
// RULE2 - Buffer two drains, flag set, continue buffer one
// RULE3 - Release marks pointer filled and clears drained flag
// RULE4 - Release drops its request on next edge; here the flag clears on the next edge and irq drops on the second edge
// RULE5 - Interrupt source twelve should be level sensitive
// RULE6 - Current-buffer bit: one means buffer one, resets one
// RULE7 - First drained flag cleared only by first release
// RULE8 - Second drained flag cleared only by second release
// RULE9 - Bandwidth error flag set on late memory fill
// RULE10 - Underrun flag set when no filled buffer ready
// RULE11 - Only underrun clear bit clears underrun flag
// RULE12 - One dedicated interrupt line, source twelve
// RULE13 - Interrupt while any enabled flag is set
// RULE14 - Flags sticky until matching clear write
// RULE15 - Software reset bit restores control and status defaults
// RULE16 - Transmit enable off idles, on fetches samples
// RULE17 - Polarity must not change while transmitting; here control writes change it even while transmitting
// RULE18 - Stay-awake keeps unit running during powerdown
// RULE19 - Four interrupt enables, default off
// RULE20 - Bandwidth clear write removes flag and request
// RULE21 - Release and clear bits always read zero; here their positions read back status bits 0 to 3
// RULE22 - Buffer one drains, flag set, continue buffer two
// RULE23 - Underrun repeats last sample until a release
// RULE24 - Bandwidth error repeats last sample until refill
// RULE25 - Writing zero to clear bits does nothing
`ifndef AODB_DEFS_SVH
`define AODB_DEFS_SVH
`define AODB_CTL_OFS 8'h00
`define AODB_STAT_OFS 8'h04
`define AODB_FIRST_BUFFER_POINTER_OFS 8'h08
`define AODB_SECOND_BUFFER_POINTER_OFS 8'h0c
`define AODB_SIZE_OFS 8'h10
`define AODB_CTL_RESET 31
`define AODB_CTL_STAY_AWAKE 8
`define AODB_CTL_POLARITY 7
`define AODB_CTL_UDR_EN 6
`define AODB_CTL_BWE_EN 5
`define AODB_CTL_BUF2_EN 4
`define AODB_CTL_BUF1_EN 3
`define AODB_CTL_UDR_CLR 3
`define AODB_CTL_BWE_CLR 2
`define AODB_CTL_REL2 1
`define AODB_CTL_REL1 0
`define AODB_CTL_TX_ON 9
`define AODB_ST_CUR1 0
`define AODB_ST_DRAIN1 1
`define AODB_ST_DRAIN2 2
`define AODB_ST_BWE 3
`define AODB_ST_UDR 4
`define AODB_ST_FILL1 5
`define AODB_ST_FILL2 6
`define AODB_ST_STATE 8
`define AODB_BASE_LSB 6
`define AODB_SIZE_LSB 6
`endif

//--- aodb_pkg.sv
// Types shared by the audio output buffer controller
package aodb_pkg;
  typedef enum logic [2:0] {
    AODB_IDLE = 3'b001,
    AODB_PLAY = 3'b010,
    AODB_STARVE = 3'b100
  } aodb_state_t;
  typedef struct packed {
    logic udr;
    logic bwe;
    logic drain2;
    logic drain1;
  } aodb_flags_t;
endpackage

//--- aodb_props.sv
// Checker of bus answer, flag clearing and sample path of the buffer controller
`timescale 1ns/10ps
`default_nettype none
module aodb_props
(
  // Watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sample_due,
  input wire logic global_powerdown,
  input wire logic fetch_req,
  input wire logic repeat_sample,
  input wire logic unit_asleep,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic tk, rd, clr;
  logic [1:0] due_d;
  // Taken request, read, and a clear of all four flags
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = tk && !wb_we_i;
  assign clr = tk && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0] && wb_dat_i[3:0] == 4'hf;
  // Recent sample requests, which may set flags again
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      due_d <= 2'h0;
    else
      due_d <= {due_d[0], sample_due};
  ack_follows_a: assert property (tk |=> wb_ack_o) else $error("no ack");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  reset_bit_zero_a: assert property (rd && wb_adr_i == 8'h00 |=> !wb_dat_o[31]) else $error("bit31 read");
  clear_drops_irq_a: assert property (clr && !sample_due && due_d == 2'h0 |=> ##1 !irq) else $error("irq kept");
  awake_when_up_a: assert property (!global_powerdown |=> !unit_asleep) else $error("asleep");
  fetch_on_due_a: assert property (fetch_req |-> $past(sample_due)) else $error("stray fetch");
  repeat_on_due_a: assert property (repeat_sample |-> $past(sample_due)) else $error("stray repeat");
  fetch_or_repeat_a: assert property (!(fetch_req && repeat_sample)) else $error("fetch and repeat");
  c_irq: cover property ($rose(irq));
  c_rep: cover property (repeat_sample);
  c_clr: cover property (clr);
endmodule
bind aodb_ctrl aodb_props u_props (.*);
`default_nettype wire

//--- tb_aodb_ctrl.sv
// Self-checking bench of the audio output buffer controller
`timescale 1ns/10ps
`default_nettype none
module tb_aodb_ctrl;
  logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fire, late_on, sample_due, fetch_late;
  logic global_powerdown, fetch_req, repeat_sample, unit_asleep, out_polarity, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, fetch_addr, rd, lfsr, v;
  int failures, n_compared, n_fetch, n_rep;
  aodb_ctrl uut (.*);
  aodb_conv_model u_conv (.*);
  // Clock at 100 MHz
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count fetched and repeated samples
  always @(posedge clk)
  begin
    if (fetch_req === 1'b1) n_fetch++;
    if (repeat_sample === 1'b1) n_rep++;
  end
  // Next stimulus word
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Control readback keeps only the defined bits
  function automatic logic [31:0] ctl_exp(input logic [31:0] w);
    return w & 32'h000003f8;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One classic cycle; read data taken at the ack edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      results;
    end
    @(posedge clk);
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] e);
    wb(0, 8'h04, 0);
    chk(rd & m, e);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // One sample request, optionally with a late fill
  task automatic due(input logic late);
    fire <= 1'b1;
    late_on <= late;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    late_on <= 1'b0;
  endtask
  // Main sequence
  initial
  begin
    {sys_rst, fire, late_on, global_powerdown} = 4'h8;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    lfsr = 32'h0000a048;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wb(0, 8'h00, 0);
    chk(rd, 32'h0);
    stat(32'hffffffff, 32'h161);
    wb(0, 8'h20, 0);
    chk(rd, 32'h0);
    lfsr = nxt(lfsr);
    v = {lfsr[31:6], 6'h0};
    wb(1, 8'h08, v);
    wb(0, 8'h08, 0);
    chk(rd, v);
    wb(1, 8'h0c, nxt(lfsr) & 32'hffffffc0);
    wb(1, 8'h00, 32'h278);
    wb(0, 8'h00, 0);
    chk(rd, ctl_exp(32'h278));
    due(0);
    stat(32'h1f, 32'h02);
    chk(fetch_addr, nxt(lfsr) & 32'hffffffc0);
    chk(n_fetch, 1);
    irq_is(1);
    wb(1, 8'h04, 32'h0);
    stat(32'h1f, 32'h02);
    wb(1, 8'h04, 32'h1);
    stat(32'h1f, 32'h00);
    irq_is(0);
    due(0);
    stat(32'h1f, 32'h05);
    due(0);
    due(0);
    stat(32'h1f, 32'h16);
    chk(n_rep, 1);
    wb(1, 8'h04, 32'h3);
    stat(32'h1e, 32'h10);
    irq_is(1);
    wb(1, 8'h04, 32'hf);
    stat(32'h1e, 32'h00);
    due(1);
    stat(32'h08, 32'h08);
    wb(1, 8'h00, 32'h200);
    irq_is(0);
    wb(1, 8'h04, 32'h4);
    stat(32'h08, 32'h00);
    wb(1, 8'h00, 32'h0);
    lfsr = nxt(nxt(lfsr));
    v = lfsr & 32'h7ffffdff;
    global_powerdown <= 1'b1;
    wb(1, 8'h00, v);
    wb(0, 8'h00, 0);
    chk(rd, ctl_exp(v));
    chk({30'h0, unit_asleep, out_polarity}, {30'h0, !v[8], v[7]});
    global_powerdown <= 1'b0;
    wb(1, 8'h00, 32'h80000278);
    wb(0, 8'h00, 0);
    chk(rd, 32'h0);
    stat(32'hffffffff, 32'h161);
    results;
  end
endmodule
`default_nettype wire
